// ==== rtl/mdr_decode.sv ====
// microword decoder with register file addressing
// assumes microword, strobes and flags come from same-clock logic;
// bus data lines come from pins and are synchronised here
`timescale 1ns/100ps
module mdr_decode (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [mdr_pkg::MW_W-1:0] micro_instr_bus_i,
  input wire logic mw_valid_i,
  input wire logic [mdr_pkg::JADDR_W-1:0] loc_counter_i,
  input wire logic [mdr_pkg::FLAG_W-1:0] flags_i,
  input wire logic indirect_cond_bit_i,
  input wire logic [mdr_pkg::BYTE_W-1:0] alu_result_i,
  input wire logic [mdr_pkg::MW_W-1:0] wide_data_addr_lines_i,
  input wire logic wr_en_i,
  input wire logic [1:0] wr_src_i,
  input wire logic load_indirect_low_i,
  input wire logic input_word_op_i,
  output logic [mdr_pkg::MW_W-1:0] micro_instr_latch_o,
  output logic busy_o,
  output logic jump_o,
  output logic return_from_sub_o,
  output logic cond_jump_taken_o,
  output logic [mdr_pkg::JADDR_W-1:0] jump_addr_o,
  output logic is_literal_o,
  output logic is_word_o,
  output logic phase_o,
  output logic [mdr_pkg::BYTE_W-1:0] literal_o,
  output logic operand_valid_o,
  output logic [mdr_pkg::BYTE_W-1:0] operand_a_o,
  output logic [mdr_pkg::BYTE_W-1:0] operand_b_o,
  output logic flag_commit_o,
  output logic result_zero_o,
  output logic result_neg_o,
  output logic [mdr_pkg::BASE_W-1:0] indirect_base_o
);
  import mdr_pkg::*;

  typedef enum logic [1:0] {
    MDR_IDLE,
    MDR_READ,
    MDR_EXEC
  } mdr_state_t;

  mdr_state_t state;
  mdr_state_t next_state;
  logic [MW_W-1:0] latch;
  logic phase;
  logic [BASE_W-1:0] base;
  logic low_zero;
  logic [MW_W-1:0] bus_meta;
  logic [MW_W-1:0] bus_sync;

  // decoded fields
  wire [3:0] opcode = latch[OP_MSB:OP_LSB];
  wire dec_jump = opcode == OP_JUMP;
  wire dec_cjump = opcode == OP_CJUMP;
  wire dec_reg = opcode >= OP_REG_WORD_LO;
  wire dec_lit = (opcode >= OP_LIT_LO) && !dec_reg;
  wire dec_word = dec_reg && (opcode < OP_REG_BYTE_LO);
  wire dec_rfs = dec_jump && latch[RFS_BIT];
  wire [3:0] cond_sel = latch[COND_MSB:COND_LSB];

  // c4 is not testable; the indirect condition bit takes its place
  wire [FLAG_W-1:0] test_vec;
  assign test_vec = {flags_i[FLAG_W-1:FL_C4+1], indirect_cond_bit_i,
                     flags_i[FL_C4-1:0]};
  // upper half of the selector tests for a clear bit
  wire cond_hit = test_vec[cond_sel[2:0]] ^ cond_sel[3];

  // page-local target on the updated location counter
  wire [JADDR_W-1:0] cjump_target;
  assign cjump_target = {loc_counter_i[JADDR_W-1:PAGE_W],
                         latch[PAGE_W-1:0]};

  // register field resolution, low bit flipped in second word cycle
  wire [FIELD_W-1:0] field_a;
  wire [FIELD_W-1:0] field_b;
  assign field_a = {latch[AF_MSB:AF_LSB+1], latch[AF_LSB] ^ phase};
  assign field_b = {latch[BF_MSB:BF_LSB+1], latch[BF_LSB] ^ phase};

  function automatic logic [RF_AW-1:0] resolve(
    input logic [FIELD_W-1:0] f,
    input logic [BASE_W-1:0] g
  );
    logic [FIELD_W-1:0] ind;
    ind = {g, f[0]};
    if (f[FIELD_W-1:1] == 3'h0) begin
      resolve = {1'b0, ind};
    end else if (f >= SHARED_LO) begin
      resolve = {1'b0, f};
    end else begin
      resolve = RF_AW'({1'b0, f} + DIRECT_OFS);
    end
  endfunction

  wire [RF_AW-1:0] addr_a = resolve(field_a, base);
  wire [RF_AW-1:0] addr_b = resolve(field_b, base);

  // write source select for the A port
  logic [BYTE_W-1:0] wr_data;
  always_comb begin
    case (mdr_src_t'(wr_src_i))
      MDR_SRC_ALU: wr_data = alu_result_i;
      MDR_SRC_FLAGS: wr_data = flags_i;
      MDR_SRC_BUS_LO: wr_data = bus_sync[BYTE_W-1:0];
      default: wr_data = bus_sync[MW_W-1:BYTE_W];
    endcase
  end

  wire in_exec = state == MDR_EXEC;
  wire operand_op = dec_lit || dec_reg;
  // writes only land while an operand op executes
  wire rf_write = in_exec && operand_op && wr_en_i;
  wire last_cycle = in_exec && !(dec_word && !phase);
  wire second_cycle = in_exec && dec_word && !phase;
  wire take_word = (state == MDR_IDLE) && mw_valid_i;
  wire half_zero = alu_result_i == 8'h00;

  always_comb begin
    next_state = state;
    case (state)
      MDR_IDLE: begin
        if (mw_valid_i) begin
          next_state = MDR_READ;
        end
      end
      MDR_READ: begin
        if (operand_op) begin
          next_state = MDR_EXEC;
        end else begin
          next_state = MDR_IDLE;
        end
      end
      MDR_EXEC: begin
        if (second_cycle) begin
          next_state = MDR_READ;
        end else begin
          next_state = MDR_IDLE;
        end
      end
      default: next_state = MDR_IDLE;
    endcase
  end

  mdr_regfile u_rf (
    .ref_clk_i(ref_clk_i),
    .clk_en_i(clk_en_i),
    .addr_a_i(addr_a),
    .addr_b_i(addr_b),
    .wr_en_i(rf_write),
    .wr_data_i(wr_data),
    .rd_a_o(operand_a_o),
    .rd_b_o(operand_b_o)
  );

  // bus data pins come from outside the clock domain
  always_ff @(posedge ref_clk_i) begin
    if (clk_en_i) begin
      bus_meta <= wide_data_addr_lines_i;
      bus_sync <= bus_meta;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state <= MDR_IDLE;
      phase <= 1'b0;
    end else if (clk_en_i) begin
      state <= next_state;
      if (second_cycle) begin
        phase <= 1'b1;
      end else if (next_state == MDR_IDLE) begin
        phase <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      latch <= MW_RST;
    end else if (clk_en_i && take_word) begin
      latch <= micro_instr_bus_i;
    end
  end

  // no increment, decrement or clear path exists for the base
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      base <= BASE_RST;
    end else if (clk_en_i) begin
      if (load_indirect_low_i) begin
        base <= latch[LIT_LSB+BASE_W-1:LIT_LSB];
      end else if (input_word_op_i) begin
        base <= bus_sync[BASE_W-1:0];
      end
    end
  end

  // jump strobes pulse for one cycle after the word is latched
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      jump_o <= 1'b0;
      return_from_sub_o <= 1'b0;
      cond_jump_taken_o <= 1'b0;
      jump_addr_o <= '0;
    end else if (clk_en_i) begin
      jump_o <= (state == MDR_READ) && dec_jump && !dec_rfs;
      return_from_sub_o <= (state == MDR_READ) && dec_rfs;
      cond_jump_taken_o <= (state == MDR_READ) && dec_cjump && cond_hit;
      if (state == MDR_READ) begin
        if (dec_cjump) begin
          jump_addr_o <= cjump_target;
        end else begin
          jump_addr_o <= latch[JADDR_W-1:0];
        end
      end
    end
  end

  // literal is a fixed field of the word, never written by execution
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      is_literal_o <= 1'b0;
      is_word_o <= 1'b0;
      literal_o <= '0;
      operand_valid_o <= 1'b0;
      phase_o <= 1'b0;
    end else if (clk_en_i) begin
      operand_valid_o <= (state == MDR_READ) && operand_op;
      phase_o <= phase;
      if (state == MDR_READ) begin
        is_literal_o <= dec_lit;
        is_word_o <= dec_word;
        literal_o <= latch[LIT_MSB:LIT_LSB];
      end
    end
  end

  // whole-result flags: word zero needs both halves zero
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      low_zero <= 1'b0;
      flag_commit_o <= 1'b0;
      result_zero_o <= 1'b0;
      result_neg_o <= 1'b0;
    end else if (clk_en_i) begin
      if (second_cycle) begin
        low_zero <= half_zero;
      end
      flag_commit_o <= last_cycle;
      if (last_cycle) begin
        result_zero_o <= half_zero && (!dec_word || low_zero);
        result_neg_o <= alu_result_i[BYTE_W-1];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      busy_o <= 1'b0;
      micro_instr_latch_o <= MW_RST;
      indirect_base_o <= BASE_RST;
    end else if (clk_en_i) begin
      busy_o <= next_state != MDR_IDLE;
      micro_instr_latch_o <= take_word ? micro_instr_bus_i : latch;
      indirect_base_o <= next_base_view(load_indirect_low_i, input_word_op_i);
    end
  end

  function automatic logic [BASE_W-1:0] next_base_view(
    input logic ld_lit,
    input logic ld_bus
  );
    if (ld_lit) begin
      next_base_view = latch[LIT_LSB+BASE_W-1:LIT_LSB];
    end else if (ld_bus) begin
      next_base_view = bus_sync[BASE_W-1:0];
    end else begin
      next_base_view = base;
    end
  endfunction
endmodule

// ==== rtl/mdr_pkg.sv ====
// package for the microword decoder and register file
// assumes a single 20 MHz clock domain and no register bus
// Functional notes
// - each delivered microword is latched; only bus bits 15:0 are kept.
// - opcode 0 is unconditional jump to an 11-bit target.
// - jump format with bit 11 set means return from subroutine, one level.
// - opcode 0001 is conditional jump; bits 11:8 pick the condition.
// - conditions test status bits, condition codes and the indirect condition bit.
// - taken conditional jump loads only 8 address bits, staying in page.
// - upper 3 target bits come from the updated location counter.
// - literal format carries constant in bits 11:4, A register in 3:0.
// - literal words take one micromachine cycle through the A port.
// - register format B field in bits 7:4 reads a read-only port.
// - byte register ops take one cycle, word ops two consecutive cycles.
// - second word cycle complements each register field's low bit.
// - flags reflect the whole byte or word result, not one half.
// - register file holds 26 bytes, direct, indirect or both.
// - field top three bits zero means indirect: base register plus low bit.
// - both fields share one indirect base and may mix modes.
// - file writes only via A port, one byte, from four sources.
// - indirect base changes only by its two load operations.
package mdr_pkg;
  localparam int MW_W = 16;
  localparam int JADDR_W = 11;
  localparam int BYTE_W = 8;
  localparam int FIELD_W = 4;
  localparam int RF_DEPTH = 26;
  localparam int RF_AW = 5;
  localparam int BASE_W = 3;
  localparam int FLAG_W = 8;
  localparam logic [3:0] OP_JUMP = 4'h0;
  localparam logic [3:0] OP_CJUMP = 4'h1;
  localparam logic [3:0] OP_LIT_LO = 4'h2;
  localparam logic [3:0] OP_REG_WORD_LO = 4'h8;
  localparam logic [3:0] OP_REG_BYTE_LO = 4'hC;
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 12;
  localparam int RFS_BIT = 11;
  localparam int COND_MSB = 11;
  localparam int COND_LSB = 8;
  localparam int LIT_MSB = 11;
  localparam int LIT_LSB = 4;
  localparam int BF_MSB = 7;
  localparam int BF_LSB = 4;
  localparam int AF_MSB = 3;
  localparam int AF_LSB = 0;
  localparam int PAGE_W = 8;
  // flag register layout
  localparam int FL_C4 = 5;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 8'h00;
  localparam logic [MW_W-1:0] MW_RST = 16'h0000;
  localparam logic [BASE_W-1:0] BASE_RST = 3'h0;
  // direct codes from this one up share slots with indirect ones
  localparam logic [FIELD_W-1:0] SHARED_LO = 4'hC;
  localparam logic [RF_AW-1:0] DIRECT_OFS = 5'h0E;
  typedef enum logic [1:0] {
    MDR_SRC_ALU,
    MDR_SRC_FLAGS,
    MDR_SRC_BUS_LO,
    MDR_SRC_BUS_HI
  } mdr_src_t;
endpackage

// ==== rtl/mdr_regfile.sv ====
// 26-byte register file, one read/write port A and one read-only port B
// assumes addresses already resolved; read data registered
`timescale 1ns/100ps
module mdr_regfile (
  input wire logic ref_clk_i,
  input wire logic clk_en_i,
  input wire logic [mdr_pkg::RF_AW-1:0] addr_a_i,
  input wire logic [mdr_pkg::RF_AW-1:0] addr_b_i,
  input wire logic wr_en_i,
  input wire logic [mdr_pkg::BYTE_W-1:0] wr_data_i,
  output logic [mdr_pkg::BYTE_W-1:0] rd_a_o,
  output logic [mdr_pkg::BYTE_W-1:0] rd_b_o
);
  import mdr_pkg::*;
  logic [BYTE_W-1:0] mem [RF_DEPTH];

  // no reset: contents are undefined until software writes them
  always_ff @(posedge ref_clk_i) begin
    if (clk_en_i) begin
      rd_a_o <= mem[addr_a_i];
      rd_b_o <= mem[addr_b_i];
      if (wr_en_i) begin
        mem[addr_a_i] <= wr_data_i;
      end
    end
  end
endmodule

// ==== bench/mdr_chk_assertions.sv ====
// port assertions for the microword decoder
// bound onto mdr_decode from the bench top; single clock domain
`timescale 1ns/100ps
module mdr_chk (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [15:0] micro_instr_bus_i,
  input wire logic mw_valid_i,
  input wire logic [10:0] loc_counter_i,
  input wire logic load_indirect_low_i,
  input wire logic input_word_op_i,
  input wire logic [15:0] micro_instr_latch_o,
  input wire logic busy_o,
  input wire logic jump_o,
  input wire logic return_from_sub_o,
  input wire logic cond_jump_taken_o,
  input wire logic [10:0] jump_addr_o,
  input wire logic phase_o,
  input wire logic operand_valid_o,
  input wire logic flag_commit_o,
  input wire logic [2:0] indirect_base_o
);
  import mdr_pkg::*;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  wire tk = mw_valid_i & ~busy_o & clk_en_i;
  wire [3:0] op = micro_instr_bus_i[15:12];
  a_take_latch: assert property (
    tk |=> busy_o && micro_instr_latch_o == $past(micro_instr_bus_i)) else $error("bad latch");
  a_jump_target: assert property (
    tk && op == OP_JUMP && !micro_instr_bus_i[11] |=> ##1 jump_o &&
    jump_addr_o == $past(micro_instr_bus_i[10:0], 2)) else $error("bad jump");
  a_return_sub: assert property (
    tk && op == OP_JUMP && micro_instr_bus_i[11] |=> ##1 return_from_sub_o && !jump_o)
    else $error("bad return");
  a_cond_page: assert property (
    cond_jump_taken_o |-> micro_instr_latch_o[15:12] == OP_CJUMP &&
    jump_addr_o == {$past(loc_counter_i[10:8]), micro_instr_latch_o[7:0]})
    else $error("bad cond jump");
  a_lit_single: assert property (
    tk && op inside {[2:7]} |=> ##1 operand_valid_o ##1 flag_commit_o && !busy_o)
    else $error("bad literal timing");
  a_byte_single: assert property (
    tk && op >= OP_REG_BYTE_LO |=> ##1 operand_valid_o ##1 flag_commit_o && !busy_o)
    else $error("bad byte timing");
  a_word_two: assert property (
    tk && op inside {[8:11]} |=> ##1 operand_valid_o && !phase_o ##2 operand_valid_o &&
    phase_o ##1 flag_commit_o && !busy_o) else $error("bad word timing");
  a_base_hold: assert property (
    !load_indirect_low_i && !input_word_op_i |=> $stable(indirect_base_o))
    else $error("base moved");
  a_base_load: assert property (
    load_indirect_low_i && clk_en_i |=> indirect_base_o == $past(micro_instr_latch_o[6:4]))
    else $error("bad base load");
  c_word: cover property (tk && op inside {[8:11]});
  c_cond: cover property (cond_jump_taken_o);
  c_ret: cover property (return_from_sub_o);
endmodule

// ==== bench/mdr_cs_model.sv ====
// control store and sequencer stand-in, one microword at a time
// called just after a rising edge; holds word until the take edge
`timescale 1ns/100ps
module mdr_cs_model (
  input wire logic ref_clk_i,
  input wire logic busy_i,
  output logic [15:0] mw_o,
  output logic valid_o,
  output logic [10:0] loc_o
);
  initial begin
    mw_o = 16'h0000;
    valid_o = 1'h0;
    loc_o = 11'h000;
  end
  task automatic offer(input logic [15:0] w, input logic [10:0] l, output bit ok);
    logic b;
    ok = 0;
    mw_o = w;
    loc_o = l;
    valid_o = 1'h1;
    for (int n = 0; n < 40 && !ok; n++) begin
      b = busy_i;
      @(posedge ref_clk_i);
      ok = (b === 1'h0);
    end
    #1;
    valid_o = 1'h0;
    // released bus must not show the stale word
    mw_o = ~w;
  endtask
endmodule

// ==== bench/tb.sv ====
// bench top: decoder against a behavioural model
// needs mdr_pkg, mdr_decode, mdr_cs_model and mdr_chk
`timescale 1ns/100ps
module tb;
  import mdr_pkg::*;
  logic ref_clk_i = 0;
  logic reset_i = 1;
  logic clk_en_i = 1;
  logic [15:0] micro_instr_bus_i, micro_instr_latch_o, wide_data_addr_lines_i = 0;
  logic mw_valid_i, busy_o, jump_o, return_from_sub_o, cond_jump_taken_o, is_literal_o;
  logic is_word_o, phase_o, operand_valid_o, flag_commit_o, result_zero_o, result_neg_o;
  logic [10:0] loc_counter_i, jump_addr_o;
  logic [7:0] flags_i = 0, alu_result_i = 0, literal_o, operand_a_o, operand_b_o;
  logic indirect_cond_bit_i = 0, wr_en_i = 0, load_indirect_low_i = 0, input_word_op_i = 0;
  logic [1:0] wr_src_i = 0;
  logic [2:0] indirect_base_o, gb = 0;
  logic [15:0] lw = 0;
  logic [7:0] rf [26];
  bit kn [26];
  int failures = 0, checked = 0, k;
  always #25 ref_clk_i = ~ref_clk_i;
  mdr_cs_model u_mdr_cs_model (.ref_clk_i, .busy_i(busy_o), .mw_o(micro_instr_bus_i),
    .valid_o(mw_valid_i), .loc_o(loc_counter_i));
  mdr_decode u_mdr_decode (.ref_clk_i, .reset_i, .clk_en_i, .micro_instr_bus_i, .mw_valid_i,
    .loc_counter_i, .flags_i, .indirect_cond_bit_i, .alu_result_i, .wide_data_addr_lines_i,
    .wr_en_i, .wr_src_i, .load_indirect_low_i, .input_word_op_i, .micro_instr_latch_o,
    .busy_o, .jump_o, .return_from_sub_o, .cond_jump_taken_o, .jump_addr_o, .is_literal_o,
    .is_word_o, .phase_o, .literal_o, .operand_valid_o, .operand_a_o, .operand_b_o,
    .flag_commit_o, .result_zero_o, .result_neg_o, .indirect_base_o);
  task close_out;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (e !== s) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  // model slot map: indirect fields take the base, 2..11 sit above 15
  function automatic int sl(input logic [3:0] f);
    return f[3:1] == 3'h0 ? int'({gb, f[0]}) : f >= 4'hC ? int'(f) : int'(f) + 14;
  endfunction
  task automatic run(input logic [15:0] w, input logic [10:0] l);
    int nj, nr, nc, nv, nf, i, a, b;
    logic [3:0] op;
    logic [7:0] tv;
    bit ok;
    op = w[15:12];
    nj = 0; nr = 0; nc = 0; nv = 0; nf = 0;
    tv = flags_i;
    tv[FL_C4] = indirect_cond_bit_i;
    u_mdr_cs_model.offer(w, l, ok);
    if (!ok) begin
      failures++;
      close_out;
    end
    lw = w;
    for (i = 0; i < 7; i++) begin
      @(posedge ref_clk_i);
      #1;
      nj += (jump_o === 1'h1);
      nr += (return_from_sub_o === 1'h1);
      nc += (cond_jump_taken_o === 1'h1);
      nv += (operand_valid_o === 1'h1);
      nf += (flag_commit_o === 1'h1);
      if (jump_o === 1'h1) chk("ja", w[10:0], jump_addr_o);
      if (cond_jump_taken_o === 1'h1) chk("ca", {l[10:8], w[7:0]}, jump_addr_o);
      if (operand_valid_o === 1'h1) begin
        a = sl(w[3:0] ^ phase_o);
        b = sl(w[7:4] ^ phase_o);
        chk("latch", w, micro_instr_latch_o);
        chk("kind", {op < 8, op > 7 && op < 12}, {is_literal_o, is_word_o});
        if (kn[a]) chk("opa", rf[a], operand_a_o);
        if (op < 8) begin
          chk("lit", w[11:4], literal_o);
          rf[a] = wr_src_i == 0 ? alu_result_i : wr_src_i == 1 ? flags_i :
            wr_src_i == 2 ? wide_data_addr_lines_i[7:0] : wide_data_addr_lines_i[15:8];
          kn[a] = 1;
        end else if (kn[b]) chk("opb", rf[b], operand_b_o);
      end
      if (flag_commit_o === 1'h1)
        chk("zn", {alu_result_i == 0, alu_result_i[7]}, {result_zero_o, result_neg_o});
    end
    chk("pulses", {3'h0, op == 0 && !w[11], 3'h0, op == 0 && w[11], 3'h0,
      op == 1 && (tv[w[10:8]] ^ w[11]), op > 7 && op < 12 ? 2'h2 : op > 1 ? 2'h1 : 2'h0,
      1'h0, op > 1}, {nj[3:0], nr[3:0], nc[3:0], nv[1:0], nf[1:0]});
  endtask
  task automatic base_ld(input bit lo);
    // a load strobe seen with the enable low must leave the base alone
    clk_en_i = 0;
    load_indirect_low_i = lo;
    input_word_op_i = !lo;
    @(posedge ref_clk_i);
    #1;
    chk("frozen", gb, indirect_base_o);
    clk_en_i = 1;
    @(posedge ref_clk_i);
    #1;
    load_indirect_low_i = 0;
    input_word_op_i = 0;
    gb = lo ? lw[6:4] : wide_data_addr_lines_i[2:0];
    @(posedge ref_clk_i);
    #1;
    chk("base", gb, indirect_base_o);
  endtask
  initial begin
    logic [15:0] w;
    void'($urandom(32'hBEE0F267));
    repeat (20) @(posedge ref_clk_i);
    #1;
    reset_i = 0;
    for (k = 0; k < 140; k++) begin
      flags_i = $urandom;
      indirect_cond_bit_i = $urandom;
      alu_result_i = k % 3 ? $urandom : 0;
      wr_src_i = $urandom;
      wide_data_addr_lines_i = $urandom;
      w = $urandom;
      if (k < 16) w[15:8] = {4'h1, 4'(k)};
      else if (k < 20) w[15:11] = {4'h0, k[0]};
      else if (k < 36) w = {4'h2, w[11:4], 4'(k - 20)};
      else w[15:12] = 4'(2 + $urandom % 14);
      wr_en_i = w[15:12] inside {[2:7]};
      run(w, $urandom);
      if (k % 10 == 5) base_ld(k % 20 == 5);
    end
    close_out;
  end
endmodule
bind mdr_decode mdr_chk u_mdr_chk (.ref_clk_i, .reset_i, .clk_en_i, .micro_instr_bus_i,
  .mw_valid_i, .loc_counter_i, .load_indirect_low_i, .input_word_op_i, .micro_instr_latch_o,
  .busy_o, .jump_o, .return_from_sub_o, .cond_jump_taken_o, .jump_addr_o, .phase_o,
  .operand_valid_o, .flag_commit_o, .indirect_base_o);
